// File: rtl/ide_dma_engine.sv
// Descriptor driven bus-master DMA engine with APB registers.
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
module ide_dma_engine (
   // Clock and reset.
   input  wire logic        MCLK,
   input  wire logic        RST_B,
   // APB slave.
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // System memory master, one word per acknowledge.
   output logic             MEM_REQ,
   output logic             MEM_WRITE,
   output logic      [31:0] MEM_ADDR,
   output logic      [31:0] MEM_WDATA,
   output logic      [3:0]  MEM_BE,
   output logic      [1:0]  MEM_BURST,
   input  wire logic        MEM_ACK,
   input  wire logic [31:0] MEM_RDATA,
   // Interface side of the disk-write FIFO.
   input  wire logic        WF_POP,
   output logic      [31:0] WF_DATA,
   output logic             WF_VALID,
   output logic             WF_EMPTY,
   // Interface side of the disk-read FIFO.
   input  wire logic        RF_PUSH,
   input  wire logic [31:0] RF_DATA,
   output logic             RF_FULL,
   // Interface control and completion.
   output logic             IDE_DIR,
   output logic             IDE_ABORT,
   input  wire logic        DEV_INTRQ,
   output logic             IRQ
);
   import ide_dma_pkg::*;

   dma_state_t  state;          // Engine state.
   logic        start;          // Start bit as last written.
   logic        dir;            // One moves disk data into memory.
   logic [31:0] tbl_ptr;        // Descriptor table pointer.
   logic [31:0] desc_ptr;       // Address of the descriptor being fetched, then of the next one.
   logic [31:0] cur_addr;       // Memory address of the next word.
   logic [16:0] rem;            // Bytes left in this region.
   logic        end_of_table_flag;            // Region is the last of the table.
   logic        active;         // Channel busy.
   logic        intr_stat;      // Completion flag.
   logic        dev_done;       // Device raised its completion line.
   logic        rf_taken;       // Popped read word waits for memory.
   logic        fifo_clr;       // Flush pulse to both FIFOs.
   logic [2:0]  irq_sync;       // Pin synchroniser for the device line.
   logic        irq_lvl;        // Filtered device line.
   logic        irq_lvl_d;      // Previous filtered level.
   logic        wr_acc;         // APB write taking effect.
   logic        ctrl_wr;        // That write hits control.
   logic        launch;         // Start bit goes from zero to one.
   logic        abort;          // Start cleared while busy.
   logic        done_evt;       // Transfer completes this cycle.
   logic        wf_full;        // Disk-write FIFO full.
   logic        wf_empty;       // Disk-write FIFO empty.
   logic        wf_push;        // Memory word into disk-write FIFO.
   logic        wf_pop;         // Interface takes a word.
   logic        rf_empty;       // Disk-read FIFO empty.
   logic        rf_pop;         // Engine takes a read word.
   logic [31:0] rf_rdata;       // Word taken from disk-read FIFO.
   logic [3:0]  be;             // Lanes of the next data word.
   logic [16:0] step;           // Bytes in the next data word.

   // True for the three mapped word offsets.
   function automatic logic reg_hit(input logic [7:0] a);
      return (a == CTRL_OFS) || (a == STAT_OFS) || (a == PTR_OFS);
   endfunction : reg_hit

   // Read view of the registers; unmapped offsets read zero.
   function automatic logic [31:0] reg_view(input logic [7:0] a,
                                            input logic [31:0] ctl,
                                            input logic [31:0] sts,
                                            input logic [31:0] ptr);
      logic [31:0] v;
      v = 32'h0000_0000;
      if (a == CTRL_OFS) begin
         v = ctl;
      end else if (a == STAT_OFS) begin
         v = sts;
      end else if (a == PTR_OFS) begin
         v = ptr;
      end
      return v;
   endfunction : reg_view

   assign wr_acc  = PSEL & PENABLE & PWRITE & PREADY;
   assign ctrl_wr = wr_acc & (PADDR == CTRL_OFS);
   assign launch  = ctrl_wr & PWDATA[START_BIT] & ~start & ~active;  // [RULE9]
   assign abort   = ctrl_wr & ~PWDATA[START_BIT] & active;           // [RULE18]

   // Counts are even, so the tail of a region is two or four bytes.
   assign step = (rem >= WORD_BYTES) ? WORD_BYTES : HALF_BYTES;
   assign be   = (rem >= WORD_BYTES) ? 4'hf : 4'h3;

   // Disk writes: memory words fill the write FIFO.
   assign wf_push = (state == S_XFER) & MEM_REQ & ~MEM_WRITE & MEM_ACK;
   assign wf_pop  = WF_POP & ~WF_EMPTY;

   // Disk reads: one word is popped only when none is waiting.
   assign rf_pop = (state == S_XFER) & dir & ~MEM_REQ & ~rf_taken &
                   (rem != '0) & ~rf_empty & ~abort;                  // [RULE12]

   // Completion only once every byte has reached its destination,
   // whatever the device line says meanwhile.
   assign done_evt = ((state == S_XFER) & dir & end_of_table_flag & (rem == '0) &
                      ~MEM_REQ & ~rf_taken) |                         // [RULE13] [RULE14]
                     ((state == S_DRAIN) & wf_empty);                 // [RULE11]

   // The two 256-byte buffers, one per direction.
   ide_dma_fifo #(.WIDTH(32), .DEPTH(FIFO_WORDS)) u_wfifo (           // [RULE21]
      .clk   (MCLK),
      .rst_b (RST_B),
      .clear (fifo_clr),
      .push  (wf_push),
      .wdata (MEM_RDATA),
      .full  (wf_full),
      .pop   (wf_pop),
      .rdata (WF_DATA),
      .empty (wf_empty)
   );

   ide_dma_fifo #(.WIDTH(32), .DEPTH(FIFO_WORDS)) u_rfifo (
      .clk   (MCLK),
      .rst_b (RST_B),
      .clear (fifo_clr),
      .push  (RF_PUSH),
      .wdata (RF_DATA),
      .full  (RF_FULL),
      .pop   (rf_pop),
      .rdata (rf_rdata),
      .empty (rf_empty)
   );

   assign WF_EMPTY = wf_empty;

   // APB answers in the first access cycle; data is caught at setup.
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         PREADY  <= 1'b0;
         PRDATA  <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= PSEL & ~PENABLE;
         PSLVERR <= PSEL & ~PENABLE & ~reg_hit(PADDR);
         if (PSEL & ~PENABLE & ~PWRITE) begin
            PRDATA <= reg_view(PADDR,
               {28'h0, dir, 2'h0, start},
               {29'h0, intr_stat, dev_done, active},
               tbl_ptr);
         end
      end
   end

   // Control and pointer; direction and pointer hold while busy.
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         start   <= CTRL_RESET;
         dir     <= CTRL_RESET;
         tbl_ptr <= PTR_RESET;
      end else begin
         if (ctrl_wr) begin
            start <= PWDATA[START_BIT];
            if (!active) begin
               dir <= PWDATA[DIR_BIT];                                // [RULE8]
            end
         end
         if (wr_acc && (PADDR == PTR_OFS) && !active) begin
            tbl_ptr <= {PWDATA[31:2], 2'b00};                         // [RULE4]
         end
      end
   end

   // Status flags; a hardware set wins over a write-one clear.
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         active    <= 1'b0;
         intr_stat <= 1'b0;
         dev_done  <= 1'b0;
         IRQ       <= 1'b0;
      end else begin
         if (launch) begin
            active <= 1'b1;
         end else if (abort || done_evt) begin
            active <= 1'b0;                                           // [RULE11] [RULE13]
         end
         if (done_evt && !abort) begin
            intr_stat <= 1'b1;
         end else if (wr_acc && (PADDR == STAT_OFS) && PWDATA[INTR_BIT]) begin
            intr_stat <= 1'b0;
         end
         if (irq_lvl && !irq_lvl_d) begin
            dev_done <= 1'b1;
         end else if (wr_acc && (PADDR == STAT_OFS) && PWDATA[DEVIRQ_BIT]) begin
            dev_done <= 1'b0;
         end
         IRQ <= intr_stat;
      end
   end

   // Device line passes three flops; the level moves once two agree.
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         irq_sync  <= 3'b000;
         irq_lvl   <= 1'b0;
         irq_lvl_d <= 1'b0;
      end else begin
         irq_sync  <= {irq_sync[1:0], DEV_INTRQ};
         if (irq_sync[1] == irq_sync[2]) begin
            irq_lvl <= irq_sync[2];
         end
         irq_lvl_d <= irq_lvl;
      end
   end

   // Interface-facing pulses and the word-valid flag.
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         fifo_clr  <= 1'b0;
         IDE_ABORT <= 1'b0;
         IDE_DIR   <= 1'b0;
         WF_VALID  <= 1'b0;
      end else begin
         // The interface finishes its word on seeing this pulse.
         fifo_clr  <= abort;                                          // [RULE20]
         IDE_ABORT <= abort;                                          // [RULE19]
         IDE_DIR   <= dir;                                            // [RULE8]
         WF_VALID  <= wf_pop;
      end
   end

   // Descriptor walk and data movement.
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         state     <= S_IDLE;
         desc_ptr  <= PTR_RESET;
         cur_addr  <= PTR_RESET;
         rem       <= '0;
         end_of_table_flag       <= 1'b0;
         rf_taken  <= 1'b0;
         MEM_REQ   <= 1'b0;
         MEM_WRITE <= 1'b0;
         MEM_ADDR  <= 32'h0000_0000;
         MEM_WDATA <= 32'h0000_0000;
         MEM_BE    <= 4'h0;
         MEM_BURST <= 2'h0;
      end else if (abort) begin
         // An open memory request is dropped, not completed.
         state    <= S_IDLE;                                          // [RULE18]
         MEM_REQ  <= 1'b0;
         rf_taken <= 1'b0;
      end else begin
         unique case (state)
            S_IDLE: begin
               if (launch) begin
                  state     <= S_FETCH0;                              // [RULE9]
                  desc_ptr  <= tbl_ptr;
                  MEM_REQ   <= 1'b1;                                  // [RULE1]
                  MEM_WRITE <= 1'b0;
                  MEM_ADDR  <= tbl_ptr;
                  MEM_BE    <= 4'hf;
                  MEM_BURST <= DESC_BURST;
               end
            end
            S_FETCH0: begin
               // First word is the region base address.
               if (MEM_ACK) begin
                  state    <= S_FETCH1;
                  cur_addr <= MEM_RDATA;                              // [RULE5]
                  MEM_ADDR <= desc_ptr + WORD_STEP;
               end
            end
            S_FETCH1: begin
               if (MEM_ACK) begin
                  state    <= S_XFER;
                  MEM_REQ  <= 1'b0;
                  {end_of_table_flag, rem} <= decode_prd(MEM_RDATA);                // [RULE2] [RULE6] [RULE7]
                  desc_ptr <= {desc_ptr[31:16],
                               desc_ptr[15:0] + PRD_STEP};            // [RULE22]
               end
            end
            S_XFER: begin
               if (MEM_REQ) begin
                  if (MEM_ACK) begin
                     MEM_REQ  <= 1'b0;
                     cur_addr <= cur_addr + WORD_STEP;
                     rem      <= rem - step;
                  end
               end else if (rem != '0) begin
                  if (!dir && !wf_full) begin
                     // Reads stop while the write FIFO is full.
                     MEM_REQ   <= 1'b1;                               // [RULE10]
                     MEM_WRITE <= 1'b0;
                     MEM_ADDR  <= cur_addr;
                     MEM_BE    <= be;
                     MEM_BURST <= DATA_BURST;
                  end else if (dir && rf_taken) begin
                     MEM_REQ   <= 1'b1;                               // [RULE12]
                     MEM_WRITE <= 1'b1;
                     MEM_ADDR  <= cur_addr;
                     MEM_WDATA <= rf_rdata;
                     MEM_BE    <= be;
                     MEM_BURST <= DATA_BURST;
                     rf_taken  <= 1'b0;
                  end else if (rf_pop) begin
                     rf_taken <= 1'b1;
                  end
               end else if (!rf_taken) begin
                  if (!end_of_table_flag) begin
                     state     <= S_FETCH0;                           // [RULE3]
                     MEM_REQ   <= 1'b1;
                     MEM_WRITE <= 1'b0;
                     MEM_ADDR  <= desc_ptr;
                     MEM_BE    <= 4'hf;
                     MEM_BURST <= DESC_BURST;
                  end else if (dir) begin
                     state <= S_IDLE;                                 // [RULE13]
                  end else begin
                     state <= S_DRAIN;                                // [RULE11]
                  end
               end
            end
            S_DRAIN: begin
               if (wf_empty) begin
                  state <= S_IDLE;                                    // [RULE11]
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_B);

   a_launch_fetch: assert property (launch |=> state == S_FETCH0 && // [RULE1]
      MEM_REQ && MEM_ADDR == $past(tbl_ptr) && MEM_BURST == DESC_BURST)
      else $error("Launch did not fetch the first descriptor.");

   a_prd_latch: assert property (state == S_FETCH1 && MEM_ACK && // [RULE7]
      !abort |=> state == S_XFER && end_of_table_flag == $past(MEM_RDATA[EOT_BIT]) &&
      rem == (($past(MEM_RDATA[15:0]) == 16'h0000) ? FULL_REGION :
              {1'b0, $past(MEM_RDATA[15:0])}))
      else $error("Descriptor count or end flag latched wrongly.");

   a_ptr_step: assert property (state == S_FETCH1 && MEM_ACK && // [RULE22]
      !abort |=> desc_ptr[15:0] == $past(desc_ptr[15:0]) + PRD_STEP)
      else $error("Descriptor pointer did not advance by eight.");

   a_next_prd: assert property (state == S_XFER && !MEM_REQ && // [RULE3]
      rem == '0 && !rf_taken && !end_of_table_flag && !abort
      |=> state == S_FETCH0 && MEM_ADDR == $past(desc_ptr))
      else $error("Next descriptor not fetched.");

   a_fifo_full_stall: assert property (state == S_XFER && // [RULE10]
      !dir && !MEM_REQ && wf_full && rem != '0 && !abort |=> !MEM_REQ)
      else $error("Memory read issued into a full FIFO.");

   a_drain_wait: assert property (state == S_DRAIN && !wf_empty && // [RULE11]
      !abort |=> state == S_DRAIN && active && !$rose(intr_stat))
      else $error("Write transfer ended before FIFO drained.");

   a_done_flags: assert property (done_evt && !abort |=> // [RULE13]
      !active && intr_stat ##1 IRQ)
      else $error("Completion flags or interrupt missing.");

   a_hold_active: assert property (active && (rem != '0 || // [RULE14]
      rf_taken) && state == S_XFER && !abort |=> active)
      else $error("Channel went idle with data outstanding.");

   a_abort_idle: assert property (abort |=> state == S_IDLE && // [RULE18]
      !MEM_REQ && IDE_ABORT && !active)
      else $error("Abort did not stop the engine at once.");

   a_fifo_flush: assert property (abort |-> ##2 // [RULE20]
      WF_EMPTY && rf_empty)
      else $error("FIFOs not flushed after abort.");

endmodule : ide_dma_engine

// File: include/ide_dma_pkg.sv
// Constants, types and decode helpers shared by the descriptor DMA engine.
//
// Behaviour
// [RULE1] Start fetches first descriptor as two-word burst.
// [RULE2] Latch descriptor count and address, then move.
// [RULE3] Without end flag, fetch the next descriptor.
// [RULE4] Software keeps table aligned, within 64 KB.
// [RULE5] Descriptor is 8 bytes; word 0 is address.
// [RULE6] Word 1 bit 31 ends table; 30-16 ignored.
// [RULE7] Word 1 bits 15-0 count; zero means 64K.
// [RULE8] Direction bit steers which FIFO the interface uses.
// [RULE9] Start bit launches engine with first fetch.
// [RULE10] Disk writes read memory until write FIFO full.
// [RULE11] Disk writes finish once write FIFO empties.
// [RULE12] Disk reads forward read FIFO words to memory.
// [RULE13] Disk reads finish when all counts are stored.
// [RULE14] Device completion never ends transfer before data.
// [RULE15] Firmware prepares everything before setting start bit.
// [RULE16] Software matches count total to command size.
// [RULE17] Firmware aborts by writing zero to start.
// [RULE18] Abort returns engine to idle at once.
// [RULE19] Interface finishes current word, then terminates.
// [RULE20] Abort flushes both FIFOs; data is invalid.
// [RULE21] Separate 256-byte, 32-bit read and write FIFOs.
// [RULE22] Descriptor pointer advances eight bytes per entry.
package ide_dma_pkg;

   // Register byte offsets on the APB.
   localparam logic [7:0]  CTRL_OFS    = 8'h00;
   localparam logic [7:0]  STAT_OFS    = 8'h04;
   localparam logic [7:0]  PTR_OFS     = 8'h08;

   // Control register fields.
   localparam int          START_BIT   = 0;
   localparam int          DIR_BIT     = 3;

   // Status register fields.
   localparam int          ACTIVE_BIT  = 0;
   localparam int          DEVIRQ_BIT  = 1;
   localparam int          INTR_BIT    = 2;

   // Reset values.
   localparam logic [31:0] PTR_RESET   = 32'h0000_0000;
   localparam logic        CTRL_RESET  = 1'b0;

   // Descriptor layout and stepping.
   localparam int          EOT_BIT     = 31;
   localparam logic [15:0] PRD_STEP    = 16'h0008;
   localparam logic [31:0] WORD_STEP   = 32'h0000_0004;
   localparam logic [16:0] FULL_REGION = 17'h1_0000;
   localparam logic [16:0] WORD_BYTES  = 17'h0_0004;
   localparam logic [16:0] HALF_BYTES  = 17'h0_0002;

   // FIFO geometry in bytes and words.
   localparam int          FIFO_BYTES  = 256;
   localparam int          FIFO_WORDS  = FIFO_BYTES / 4;

   // Words requested per memory burst.
   localparam logic [1:0]  DESC_BURST  = 2'h2;
   localparam logic [1:0]  DATA_BURST  = 2'h1;

   // Engine states, Gray coded along fetch, move, drain.
   typedef enum logic [2:0] {
      S_IDLE   = 3'b000,
      S_FETCH0 = 3'b001,
      S_FETCH1 = 3'b011,
      S_XFER   = 3'b010,
      S_DRAIN  = 3'b110
   } dma_state_t;

   // Decoded second descriptor word.
   typedef struct packed {
      logic        end_of_table_flag;
      logic [16:0] count;
   } prd_t;

   // Turns the second descriptor word into flag and byte count.
   function automatic prd_t decode_prd(input logic [31:0] w);
      prd_t p;
      p.end_of_table_flag   = w[EOT_BIT];
      p.count = (w[15:0] == 16'h0000) ? FULL_REGION : {1'b0, w[15:0]};
      return p;
   endfunction : decode_prd

endpackage : ide_dma_pkg

// File: rtl/ide_dma_fifo.sv
// Synchronous word FIFO with registered read data and flags.
`timescale 1ns/1ps
module ide_dma_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 64
) (
   // Clock and reset.
   input  wire logic             clk,
   input  wire logic             rst_b,
   // Flush.
   input  wire logic             clear,
   // Fill side.
   input  wire logic             push,
   input  wire logic [WIDTH-1:0] wdata,
   output logic                  full,
   // Drain side.
   input  wire logic             pop,
   output logic      [WIDTH-1:0] rdata,
   output logic                  empty
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] store [DEPTH];   // Word storage.
   logic [AW-1:0]    wptr;            // Next slot to fill.
   logic [AW-1:0]    rptr;            // Next slot to drain.
   logic [AW:0]      count;           // Words held.
   logic [AW:0]      next_count;      // Count after this edge.
   logic             do_push;         // Accepted fill.
   logic             do_pop;          // Accepted drain.

   // Flags are registered, so a refused push is simply ignored.
   assign do_push = push & ~full & ~clear;
   assign do_pop  = pop & ~empty & ~clear;

   // Count after this edge; a flush wins over everything.
   always_comb begin
      next_count = count;
      if (clear) begin
         next_count = '0;
      end else if (do_push & ~do_pop) begin
         next_count = count + 1'b1;
      end else if (do_pop & ~do_push) begin
         next_count = count - 1'b1;
      end
   end

   // Storage has no reset; words are only valid behind the count.
   always_ff @(posedge clk) begin
      if (do_push) begin
         store[wptr] <= wdata;
      end
   end

   // Pointers, count and flags.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wptr  <= '0;
         rptr  <= '0;
         count <= '0;
         full  <= 1'b0;
         empty <= 1'b1;
      end else begin
         count <= next_count;
         full  <= (next_count == (AW+1)'(DEPTH));
         empty <= (next_count == '0);
         if (clear) begin
            wptr <= '0;
            rptr <= '0;
         end else begin
            if (do_push) begin
               wptr <= wptr + 1'b1;
            end
            if (do_pop) begin
               rptr <= rptr + 1'b1;
            end
         end
      end
   end

   // Read data appears the cycle after an accepted pop.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata <= '0;
      end else if (do_pop) begin
         rdata <= store[rptr];
      end
   end

endmodule : ide_dma_fifo

// File: dv/mem_model.sv
// Behavioural system memory answering the engine's word requests.
`timescale 1ns/1ps
module mem_model (
   // Clock.
   input  wire logic        clk,
   // Request.
   input  wire logic        req,
   input  wire logic        wr,
   input  wire logic [31:0] addr,
   input  wire logic [31:0] wdata,
   // Answer.
   output logic             ack,
   output logic      [31:0] rdata
);
   logic [31:0] store [0:255];    // Words by address bits 9:2.
   int          seed = 32'hf36eed9d; // Fixed seed for stalls.
   int          stall = 0;        // Cycles still to wait.
   initial ack = 1'b0;
   initial rdata = 32'h0;
   // Random stalls; idle data toggles so stale data never looks fresh.
   always @(posedge clk) begin
      ack <= 1'b0;
      rdata <= ~rdata;
      if (req && !ack && stall > 0) stall--;
      else if (req && !ack) begin
         ack <= 1'b1;
         rdata <= store[addr[9:2]];
         if (wr) store[addr[9:2]] <= wdata;
         stall = $unsigned($random(seed)) % 3;
      end
   end
endmodule : mem_model

// File: dv/ide_dma_engine_test.sv
// Self-checking bench for the descriptor DMA engine.
`timescale 1ns/1ps
module ide_dma_engine_test;
   logic MCLK = 0, RST_B = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
   logic [7:0] PADDR = 0;
   logic [31:0] PWDATA = 0, PRDATA, MEM_ADDR, MEM_WDATA, MEM_RDATA;
   logic PREADY, PSLVERR, MEM_REQ, MEM_WRITE, MEM_ACK, WF_VALID;
   logic [3:0] MEM_BE;
   logic [1:0] MEM_BURST;
   logic [31:0] WF_DATA, RF_DATA = 0, q, v;
   logic WF_POP = 0, WF_EMPTY, RF_PUSH = 0, RF_FULL, IDE_DIR, IDE_ABORT;
   logic DEV_INTRQ = 0, IRQ, e;
   int err_total = 0, checked = 0, cyc = 0, i;
   int seed = 32'hf36eed9d;
   logic [31:0] dq[$] = '{'h40, 'h44, 'h48, 'h4c, 'h60, 'h64, 'h68,
                          'h6c, 'h50, 'h54};
   logic [31:0] wq[$], aq[$], vq[$]; // Expected words and writes.
   ide_dma_engine uut (.*);
   mem_model sysmem (.clk(MCLK), .req(MEM_REQ), .wr(MEM_WRITE),
      .addr(MEM_ADDR), .wdata(MEM_WDATA), .ack(MEM_ACK), .rdata(MEM_RDATA));
   always #5 MCLK = ~MCLK;
   // Compares one value and counts the outcome.
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One APB transfer; waits for the slave's ready.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      PSEL <= 1; PWRITE <= w; PADDR <= a; PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1;
      do @(posedge MCLK); while (PREADY !== 1'b1);
      q = PRDATA; e = PSLVERR;
      PSEL <= 0; PENABLE <= 0;
      @(posedge MCLK); // One idle edge, so no strobe is set twice a step.
   endtask : apb
   // Prints the counts and the verdict, then stops.
   task end_of_test;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_of_test
   // Cuts a hang short.
   always @(posedge MCLK) if (++cyc == 20000) begin
      err_total++;
      end_of_test();
   end
   // Watches every acknowledged descriptor word and memory write.
   always @(posedge MCLK) if (MEM_REQ && MEM_ACK) begin
      if (MEM_BURST == 2'h2) chk(MEM_ADDR, dq.pop_front());
      else if (MEM_WRITE) begin
         chk(MEM_ADDR, aq.pop_front());
         chk(MEM_BE, 'hf);
         chk(MEM_WDATA, vq.pop_front());
      end
   end
   initial begin
      // Aligned tables; reserved bits set in the first entry.
      for (i = 0; i < 256; i++) sysmem.store[i] = $random(seed);
      sysmem.store[16:21] = '{'h100, 'h7fff0008, 'h200, 'h80000004, 'h100,
                              'h80000104};
      sysmem.store[24:27] = '{'h300, 'h4, 'h380, 'h80000004};
      wq = '{sysmem.store[64], sysmem.store[65], sysmem.store[128]};
      repeat (2) @(posedge MCLK);
      RST_B <= 1;
      // Disk write over two regions, then drain the write FIFO.
      apb(1, 8'h08, 'h40);
      apb(1, 8'h00, 'h1);
      repeat (3) begin
         while (WF_EMPTY !== 1'b0) @(posedge MCLK);
         WF_POP <= 1;
         @(posedge MCLK);
         WF_POP <= 0;
         do @(posedge MCLK); while (WF_VALID !== 1'b1);
         chk(WF_DATA, wq.pop_front());
      end
      while (IRQ !== 1'b1) @(posedge MCLK);
      apb(0, 8'h04, 0);
      chk(q, 'h4);
      // Disk read with a device completion before the data is stored.
      apb(1, 8'h04, 'h4);
      apb(1, 8'h00, 'h0);
      apb(1, 8'h08, 'h60);
      apb(1, 8'h00, 'h9);
      aq = '{'h300, 'h380};
      repeat (2) begin
         v = $random(seed);
         vq.push_back(v);
         RF_PUSH <= 1; RF_DATA <= v;
         @(posedge MCLK);
         RF_PUSH <= 0;
         DEV_INTRQ <= 1;
         repeat (6) @(posedge MCLK);
      end
      chk(IDE_DIR, 1);
      while (IRQ !== 1'b1) @(posedge MCLK);
      apb(0, 8'h04, 0);
      chk(q, 'h6);
      // Abort a disk write after its long region has filled the FIFO.
      DEV_INTRQ <= 0;
      apb(1, 8'h04, 'h6);
      apb(1, 8'h00, 'h0);
      apb(1, 8'h08, 'h50);
      apb(1, 8'h00, 'h1);
      while (WF_EMPTY !== 1'b0) @(posedge MCLK);
      repeat (700) @(posedge MCLK);
      chk(MEM_REQ, 0);
      apb(1, 8'h00, 'h0);
      repeat (3) @(posedge MCLK);
      chk(WF_EMPTY, 1);
      apb(0, 8'h04, 0);
      chk(q, 'h0);
      // Unmapped place answers with an error and reads zero.
      apb(0, 8'h0c, 0);
      chk(q, 0);
      chk(e, 1);
      end_of_test();
   end
endmodule : ide_dma_engine_test
